/* rtl/usbepd_pkg.sv */
package usbepd_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_EP3_IN_COUNT = 8'hD1;
  localparam logic [7:0] ADDR_EP4_OUT_COUNT = 8'hD2;
  localparam logic [7:0] ADDR_EP0_RX_STATUS = 8'hD3;
  localparam logic [7:0] ADDR_BUFFER_OWNERSHIP = 8'hD6;
  localparam logic [7:0] ADDR_ENDPOINT_IRQ_EN = 8'hDA;
  localparam logic [7:0] ADDR_BUS_EVENT_IRQ_EN = 8'hDB;
  localparam logic [7:0] ADDR_BUS_RESET_TIMEOUT = 8'hDC;
  localparam logic [7:0] ADDR_PD_CONTROL = 8'hDF;
  localparam logic [7:0] ADDR_AUX_STATUS = 8'hF5;
  localparam logic [7:0] ADDR_ENDPOINT_FLAGS = 8'hC2;
  localparam logic [7:0] ADDR_BUS_EVENT_FLAGS = 8'hC3;
  localparam logic [7:0] ADDR_EP4_RX_CONTROL = 8'hCF;
  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] RST_PD_CONTROL = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int BUS_EVENT_LSB = 2;
  localparam int TIMEOUT_EN_BIT = 2;
  localparam int AUX_PRESENT_BIT = 7;
  localparam int AUX_UNPLUG_BIT = 6;
  localparam int EP4_ERR_BIT = 3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_BASE_MS = 2;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic buf4_pd_rx_owner;
    logic buf3_pd_tx_owner;
    logic buf1_bulk_assign;
    logic buf2_bulk_assign;
    logic buf1_spim_dma_assign;
    logic buf2_spim_dma_assign;
    logic buf1_par_dma_assign;
    logic buf2_par_dma_assign;
  } usbepd_owner_s;
  typedef struct packed {
    logic pd_mode_en;
    logic pd_send_ready;
    logic pd_recv_ready;
    logic cc_pin_select;
    logic cc_second_term_connect;
    logic cc_first_term_connect;
    logic [1:0] cc_termination_sel;
  } usbepd_pdctl_s;
  typedef struct packed {
    logic ep0_rx_data_pid;
    logic ep0_rx_error;
    logic ep0_direction;
    logic ep0_setup_seen;
    logic [3:0] ep0_out_length;
  } usbepd_ep0_s;
  typedef enum logic [2:0] {
    USBEPD_OWN_CPU = 3'b000,
    USBEPD_OWN_PD = 3'b001,
    USBEPD_OWN_BULK = 3'b010,
    USBEPD_OWN_SPIM = 3'b011,
    USBEPD_OWN_PAR = 3'b100
  } usbepd_owner_e;
endpackage : usbepd_pkg

/* rtl/usbepd_regs.sv */
`timescale 1ns/10ps
// Operation
// - ep4 rx error bit, 1 means error
// - ep3 in length, 7-bit RW, reset zero
// - ep4 out length, 7-bit read-only
// - ep0 data pid of last packet
// - ep0 rx error bit
// - ep0 direction, 1 means IN
// - ep0 setup token indicator
// - ep0 out length, 4-bit read-only
// - buffer 4: cpu or pd receive
// - buffer 3: cpu or pd transmit
// - bulk assign for buffers 1 and 2
// - spi and parallel dma assign bits
// - eight endpoint interrupt enables, reset zero
// - six bus event enables, bits 7..2
// - bus reset timeout only when enabled
// - timeout select 2,3,4,5 ms
// - pd mode only while enabled
// - pd send ready from firmware bit
// - pd receive ready from firmware bit
// - cc pin select and termination connects
// - cc termination select, reset 3
// - bus power present, unplug flag
// - event flags set by hw, write0 clears
module usbepd_regs #(
  parameter int CYC_PER_MS = usbepd_pkg::CYCLES_PER_MS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic ep4_rx_done_i,
  input wire logic ep4_rx_error_i,
  input wire logic [6:0] ep4_rx_length_i,
  input wire logic ep0_rx_done_i,
  input wire logic [7:0] ep0_rx_status_i,
  input wire logic [7:0] endpoint_event_i,
  input wire logic [5:0] bus_event_i,
  input wire logic bus_power_i,
  input wire logic bus_se0_i,
  output logic [6:0] ep3_in_length_o,
  output logic pd_mode_o,
  output logic pd_send_ready_o,
  output logic pd_recv_ready_o,
  output logic cc_pin_select_o,
  output logic cc_first_term_o,
  output logic cc_second_term_o,
  output logic [1:0] cc_termination_sel_o,
  output logic [2:0] buf1_owner_o,
  output logic [2:0] buf2_owner_o,
  output logic [2:0] buf3_owner_o,
  output logic [2:0] buf4_owner_o,
  output logic bus_reset_timeout_o,
  output logic irq_o
);
  initial begin
    if (CYC_PER_MS < 1) $error("CYC_PER_MS must be at least one");
  end
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [6:0] ep3_len_q, ep3_len_d;
  logic [6:0] ep4_len_q, ep4_len_d;
  logic ep4_err_q, ep4_err_d;
  usbepd_pkg::usbepd_ep0_s ep0_q, ep0_d;
  usbepd_pkg::usbepd_owner_s own_q, own_d;
  logic [7:0] ep_ie_q, ep_ie_d;
  logic [5:0] bus_ie_q, bus_ie_d;
  logic [2:0] tmo_q, tmo_d;
  usbepd_pkg::usbepd_pdctl_s pd_q, pd_d;
  logic [7:0] ep_flag_q, ep_flag_d;
  logic [5:0] bus_flag_q, bus_flag_d;
  logic unplug_q, unplug_d;
  logic power_q;
  logic [7:0] rdata_d;
  logic irq_d;
  logic wr_hit;
  always_comb begin
    ep3_len_d = ep3_len_q;
    ep4_len_d = ep4_len_q;
    ep4_err_d = ep4_err_q;
    ep0_d = ep0_q;
    own_d = own_q;
    ep_ie_d = ep_ie_q;
    bus_ie_d = bus_ie_q;
    tmo_d = tmo_q;
    pd_d = pd_q;
    ep_flag_d = ep_flag_q;
    bus_flag_d = bus_flag_q;
    unplug_d = unplug_q;
    wr_hit = 1'b0;
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        usbepd_pkg::ADDR_EP3_IN_COUNT: ep3_len_d = sfr_wdata_i[6:0];
        usbepd_pkg::ADDR_BUFFER_OWNERSHIP: own_d = sfr_wdata_i;
        usbepd_pkg::ADDR_ENDPOINT_IRQ_EN: ep_ie_d = sfr_wdata_i;
        usbepd_pkg::ADDR_BUS_EVENT_IRQ_EN: bus_ie_d = sfr_wdata_i[7:2];
        usbepd_pkg::ADDR_BUS_RESET_TIMEOUT: tmo_d = sfr_wdata_i[2:0];
        usbepd_pkg::ADDR_PD_CONTROL: pd_d = sfr_wdata_i;
        usbepd_pkg::ADDR_ENDPOINT_FLAGS: ep_flag_d = ep_flag_q & sfr_wdata_i;
        usbepd_pkg::ADDR_BUS_EVENT_FLAGS: bus_flag_d = bus_flag_q & sfr_wdata_i[7:2];
        usbepd_pkg::ADDR_AUX_STATUS: unplug_d = unplug_q & sfr_wdata_i[usbepd_pkg::AUX_UNPLUG_BIT];
        default: wr_hit = 1'b0;
      endcase
    end
    // hardware set wins over a same-cycle firmware clear
    ep_flag_d = ep_flag_d | endpoint_event_i;
    bus_flag_d = bus_flag_d | bus_event_i;
    if (power_q && !bus_power_i) unplug_d = 1'b1;
    if (ep4_rx_done_i) begin
      ep4_len_d = ep4_rx_length_i;
      ep4_err_d = ep4_rx_error_i;
    end
    if (ep0_rx_done_i) ep0_d = ep0_rx_status_i;
  end
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = usbepd_pkg::RST_ZERO;
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        usbepd_pkg::ADDR_EP3_IN_COUNT: rdata_d = {1'b0, ep3_len_q};
        usbepd_pkg::ADDR_EP4_OUT_COUNT: rdata_d = {1'b0, ep4_len_q};
        usbepd_pkg::ADDR_EP0_RX_STATUS: rdata_d = ep0_q;
        usbepd_pkg::ADDR_EP4_RX_CONTROL: rdata_d[usbepd_pkg::EP4_ERR_BIT] = ep4_err_q;
        usbepd_pkg::ADDR_BUFFER_OWNERSHIP: rdata_d = own_q;
        usbepd_pkg::ADDR_ENDPOINT_IRQ_EN: rdata_d = ep_ie_q;
        usbepd_pkg::ADDR_BUS_EVENT_IRQ_EN: rdata_d = {bus_ie_q, 2'b00};
        usbepd_pkg::ADDR_BUS_RESET_TIMEOUT: rdata_d = {5'b00000, tmo_q};
        usbepd_pkg::ADDR_PD_CONTROL: rdata_d = pd_q;
        usbepd_pkg::ADDR_ENDPOINT_FLAGS: rdata_d = ep_flag_q;
        usbepd_pkg::ADDR_BUS_EVENT_FLAGS: rdata_d = {bus_flag_q, 2'b00};
        usbepd_pkg::ADDR_AUX_STATUS: rdata_d = {power_q, unplug_q, 6'b000000};
        default: rdata_d = usbepd_pkg::RST_ZERO;
      endcase
    end
    irq_d = |(ep_flag_q & ep_ie_q) | |(bus_flag_q & bus_ie_q);
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ep3_len_q <= 7'h00;
      ep4_len_q <= 7'h00;
      ep4_err_q <= 1'b0;
      ep0_q <= usbepd_pkg::RST_ZERO;
      own_q <= usbepd_pkg::RST_ZERO;
      ep_ie_q <= usbepd_pkg::RST_ZERO;
      bus_ie_q <= 6'h00;
      tmo_q <= 3'h0;
      pd_q <= usbepd_pkg::RST_PD_CONTROL;
      ep_flag_q <= usbepd_pkg::RST_ZERO;
      bus_flag_q <= 6'h00;
      unplug_q <= 1'b0;
      power_q <= 1'b0;
      sfr_rdata_o <= usbepd_pkg::RST_ZERO;
      irq_o <= 1'b0;
    end else begin
      ep3_len_q <= ep3_len_d;
      ep4_len_q <= ep4_len_d;
      ep4_err_q <= ep4_err_d;
      ep0_q <= ep0_d;
      own_q <= own_d;
      ep_ie_q <= ep_ie_d;
      bus_ie_q <= bus_ie_d;
      tmo_q <= tmo_d;
      pd_q <= pd_d;
      ep_flag_q <= ep_flag_d;
      bus_flag_q <= bus_flag_d;
      unplug_q <= unplug_d;
      power_q <= bus_power_i;
      sfr_rdata_o <= rdata_d;
      irq_o <= irq_d;
    end
  end
  // ----------------------------------------
  // bus reset timeout
  // ----------------------------------------
  // counts se0 time; limit is (2 + select) ms
  logic [31:0] tmo_cnt_q, tmo_cnt_d;
  logic [31:0] tmo_limit;
  logic tmo_hit_d;
  always_comb begin
    tmo_limit = 32'(CYC_PER_MS) * (32'(usbepd_pkg::TIMEOUT_BASE_MS) + 32'(tmo_q[1:0]));
    tmo_cnt_d = 32'h0000_0000;
    tmo_hit_d = 1'b0;
    if (tmo_q[usbepd_pkg::TIMEOUT_EN_BIT] && bus_se0_i) begin
      tmo_cnt_d = (tmo_cnt_q < tmo_limit) ? tmo_cnt_q + 32'h0000_0001 : tmo_cnt_q;
      tmo_hit_d = (tmo_cnt_d >= tmo_limit);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tmo_cnt_q <= 32'h0000_0000;
      bus_reset_timeout_o <= 1'b0;
    end else begin
      tmo_cnt_q <= tmo_cnt_d;
      bus_reset_timeout_o <= tmo_hit_d;
    end
  end
  // ----------------------------------------
  // outputs and buffer ownership
  // ----------------------------------------
  // one owner per buffer by fixed priority, so a double assign from firmware never drives two ports
  function automatic usbepd_pkg::usbepd_owner_e pick(input logic bulk, input logic spim, input logic par);
    if (bulk) return usbepd_pkg::USBEPD_OWN_BULK;
    else if (spim) return usbepd_pkg::USBEPD_OWN_SPIM;
    else if (par) return usbepd_pkg::USBEPD_OWN_PAR;
    else return usbepd_pkg::USBEPD_OWN_CPU;
  endfunction : pick
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ep3_in_length_o <= 7'h00;
      pd_mode_o <= 1'b0;
      pd_send_ready_o <= 1'b0;
      pd_recv_ready_o <= 1'b0;
      cc_pin_select_o <= 1'b0;
      cc_first_term_o <= 1'b0;
      cc_second_term_o <= 1'b0;
      cc_termination_sel_o <= 2'h3;
      buf1_owner_o <= usbepd_pkg::USBEPD_OWN_CPU;
      buf2_owner_o <= usbepd_pkg::USBEPD_OWN_CPU;
      buf3_owner_o <= usbepd_pkg::USBEPD_OWN_CPU;
      buf4_owner_o <= usbepd_pkg::USBEPD_OWN_CPU;
    end else begin
      ep3_in_length_o <= ep3_len_q;
      pd_mode_o <= pd_q.pd_mode_en;
      pd_send_ready_o <= pd_q.pd_mode_en & pd_q.pd_send_ready;
      pd_recv_ready_o <= pd_q.pd_mode_en & pd_q.pd_recv_ready;
      cc_pin_select_o <= pd_q.cc_pin_select;
      cc_first_term_o <= pd_q.cc_first_term_connect;
      cc_second_term_o <= pd_q.cc_second_term_connect;
      cc_termination_sel_o <= pd_q.cc_termination_sel;
      buf1_owner_o <= pick(own_q.buf1_bulk_assign, own_q.buf1_spim_dma_assign, own_q.buf1_par_dma_assign);
      buf2_owner_o <= pick(own_q.buf2_bulk_assign, own_q.buf2_spim_dma_assign, own_q.buf2_par_dma_assign);
      buf3_owner_o <= own_q.buf3_pd_tx_owner ? usbepd_pkg::USBEPD_OWN_PD : usbepd_pkg::USBEPD_OWN_CPU;
      buf4_owner_o <= own_q.buf4_pd_rx_owner ? usbepd_pkg::USBEPD_OWN_PD : usbepd_pkg::USBEPD_OWN_CPU;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  ep4_err_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ep4_rx_done_i |=> ep4_err_q == $past(ep4_rx_error_i))
    else $error("ep4 error bit wrong");
  ep3_len_wr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sfr_wr_i && sfr_addr_i == usbepd_pkg::ADDR_EP3_IN_COUNT) |=> ##1 ep3_in_length_o == $past(sfr_wdata_i[6:0], 2))
    else $error("ep3 length not taken");
  ep4_len_cap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ep4_rx_done_i |=> ep4_len_q == $past(ep4_rx_length_i))
    else $error("ep4 length not captured");
  ep0_status_cap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ep0_rx_done_i |=> ep0_q == $past(ep0_rx_status_i))
    else $error("ep0 status not captured");
  buf4_owner_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $past(own_q.buf4_pd_rx_owner) |-> buf4_owner_o == usbepd_pkg::USBEPD_OWN_PD)
    else $error("buffer 4 owner wrong");
  flag_set_wins_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    endpoint_event_i[0] |=> ep_flag_q[0])
    else $error("event lost");
  irq_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ep_flag_q & ep_ie_q) != 8'h00 |=> irq_o)
    else $error("irq missing");
  pd_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !$past(pd_q.pd_mode_en) |-> !pd_send_ready_o && !pd_recv_ready_o)
    else $error("pd active while disabled");
  tmo_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !tmo_q[usbepd_pkg::TIMEOUT_EN_BIT] |=> !bus_reset_timeout_o)
    else $error("timeout while disabled");
  unplug_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (power_q && !bus_power_i) |=> unplug_q)
    else $error("unplug not flagged");
  irq_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) irq_o);
  tmo_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) bus_reset_timeout_o);
  unplug_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(unplug_q));
endmodule : usbepd_regs

/* verif/usbepd_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// far side: usb host and pd partner, driving bus-side events
// ----------------------------------------
module usbepd_host_model (
  input wire logic clk_sys_i,
  output logic ep4_rx_done_o,
  output logic ep4_rx_error_o,
  output logic [6:0] ep4_rx_length_o,
  output logic ep0_rx_done_o,
  output logic [7:0] ep0_rx_status_o,
  output logic [7:0] endpoint_event_o,
  output logic [5:0] bus_event_o,
  output logic bus_power_o,
  output logic bus_se0_o
);
  initial begin
    ep4_rx_done_o = 1'b0;
    ep4_rx_error_o = 1'b0;
    ep4_rx_length_o = 7'h00;
    ep0_rx_done_o = 1'b0;
    ep0_rx_status_o = 8'h00;
    endpoint_event_o = 8'h00;
    bus_event_o = 6'h00;
    bus_power_o = 1'b0;
    bus_se0_o = 1'b0;
  end
  // packet fields are only qualified by the done pulse; outside it they show the inverse
  task automatic send_ep4(input logic err, input logic [6:0] len);
    @(posedge clk_sys_i);
    ep4_rx_done_o <= 1'b1;
    ep4_rx_error_o <= err;
    ep4_rx_length_o <= len;
    @(posedge clk_sys_i);
    ep4_rx_done_o <= 1'b0;
    ep4_rx_error_o <= ~err;
    ep4_rx_length_o <= ~len;
  endtask : send_ep4
  task automatic send_ep0(input logic [7:0] st);
    @(posedge clk_sys_i);
    ep0_rx_done_o <= 1'b1;
    ep0_rx_status_o <= st;
    @(posedge clk_sys_i);
    ep0_rx_done_o <= 1'b0;
    ep0_rx_status_o <= ~st;
  endtask : send_ep0
  task automatic pulse_events(input logic [7:0] ep, input logic [5:0] bus);
    @(posedge clk_sys_i);
    endpoint_event_o <= ep;
    bus_event_o <= bus;
    @(posedge clk_sys_i);
    endpoint_event_o <= 8'h00;
    bus_event_o <= 6'h00;
  endtask : pulse_events
  task automatic set_lines(input logic pwr, input logic se0);
    @(posedge clk_sys_i);
    bus_power_o <= pwr;
    bus_se0_o <= se0;
  endtask : set_lines
endmodule : usbepd_host_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam int CYC = 10;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o, ep0_st, ep_ev;
  logic [6:0] ep3_len, ep4_len;
  logic [5:0] bus_ev;
  logic ep4_done, ep4_err, ep0_done, pwr, se0;
  logic pd_mode, pd_send, pd_recv, cc_sel, cc_t1, cc_t2, tmo, irq;
  logic [1:0] cc_term;
  logic [2:0] b1, b2, b3, b4;
  logic [7:0] rd;
  int fails = 0;
  int total_checks = 0;
  int n;
  logic [7:0] rst_addr [6] = '{usbepd_pkg::ADDR_EP3_IN_COUNT, usbepd_pkg::ADDR_BUFFER_OWNERSHIP,
    usbepd_pkg::ADDR_ENDPOINT_IRQ_EN, usbepd_pkg::ADDR_BUS_EVENT_IRQ_EN, usbepd_pkg::ADDR_BUS_RESET_TIMEOUT,
    usbepd_pkg::ADDR_PD_CONTROL};
  logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, usbepd_pkg::RST_PD_CONTROL};
  logic [7:0] own_w [4] = '{8'hC0, 8'h24, 8'h09, 8'h12};
  logic [11:0] own_e [4] = '{12'h240, 12'h01A, 12'h023, 12'h014};
  always #12.5 clk_sys_i = ~clk_sys_i;
  usbepd_host_model host (.clk_sys_i(clk_sys_i), .ep4_rx_done_o(ep4_done), .ep4_rx_error_o(ep4_err),
    .ep4_rx_length_o(ep4_len), .ep0_rx_done_o(ep0_done), .ep0_rx_status_o(ep0_st), .endpoint_event_o(ep_ev),
    .bus_event_o(bus_ev), .bus_power_o(pwr), .bus_se0_o(se0));
  usbepd_regs #(.CYC_PER_MS(CYC)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .ep4_rx_done_i(ep4_done), .ep4_rx_error_i(ep4_err), .ep4_rx_length_i(ep4_len), .ep0_rx_done_i(ep0_done),
    .ep0_rx_status_i(ep0_st), .endpoint_event_i(ep_ev), .bus_event_i(bus_ev), .bus_power_i(pwr),
    .bus_se0_i(se0), .ep3_in_length_o(ep3_len), .pd_mode_o(pd_mode), .pd_send_ready_o(pd_send),
    .pd_recv_ready_o(pd_recv), .cc_pin_select_o(cc_sel), .cc_first_term_o(cc_t1), .cc_second_term_o(cc_t2),
    .cc_termination_sel_o(cc_term), .buf1_owner_o(b1), .buf2_owner_o(b2), .buf3_owner_o(b3),
    .buf4_owner_o(b4), .bus_reset_timeout_o(tmo), .irq_o(irq));
  // ----------------------------------------
  // access tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_sys_i);
    sfr_wr_i <= 1'b0;
    sfr_wdata_i <= ~d;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge clk_sys_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk(sfr_rdata_o, exp);
  endtask : rdchk
  // timeout must rise close to its selected count of se0 cycles, never while disabled
  task automatic tmo_run(input logic [7:0] cfg, input int exp);
    wr(usbepd_pkg::ADDR_BUS_RESET_TIMEOUT, cfg);
    host.set_lines(1'b1, 1'b1);
    n = 0;
    while (tmo !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    chk(exp == 0 ? n == 100 : (n >= exp - 1 && n <= exp + 3), 1'b1);
    host.set_lines(1'b1, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(tmo, 1'b0);
  endtask : tmo_run
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    chk(cc_term, 2'b11);
    for (int i = 0; i < 6; i++) rdchk(rst_addr[i], rst_val[i]);
    rdchk(8'h00, 8'h00);
    wr(usbepd_pkg::ADDR_EP3_IN_COUNT, 8'hFF);
    chk(ep3_len, 7'h7F);
    rdchk(usbepd_pkg::ADDR_EP3_IN_COUNT, 8'h7F);
    host.send_ep4(1'b1, 7'h55);
    rdchk(usbepd_pkg::ADDR_EP4_OUT_COUNT, 8'h55);
    rdchk(usbepd_pkg::ADDR_EP4_RX_CONTROL, 8'h08);
    wr(usbepd_pkg::ADDR_EP4_OUT_COUNT, 8'h00);
    rdchk(usbepd_pkg::ADDR_EP4_OUT_COUNT, 8'h55);
    host.send_ep4(1'b0, 7'h2A);
    rdchk(usbepd_pkg::ADDR_EP4_RX_CONTROL, 8'h00);
    rdchk(usbepd_pkg::ADDR_EP4_OUT_COUNT, 8'h2A);
    host.send_ep0(8'hD5);
    rdchk(usbepd_pkg::ADDR_EP0_RX_STATUS, 8'hD5);
    host.send_ep0(8'h2A);
    wr(usbepd_pkg::ADDR_EP0_RX_STATUS, 8'hFF);
    rdchk(usbepd_pkg::ADDR_EP0_RX_STATUS, 8'h2A);
    for (int i = 0; i < 4; i++) begin
      wr(usbepd_pkg::ADDR_BUFFER_OWNERSHIP, own_w[i]);
      chk({b4, b3, b2, b1}, own_e[i]);
    end
    wr(usbepd_pkg::ADDR_PD_CONTROL, 8'hFC);
    chk({pd_mode, pd_send, pd_recv, cc_sel, cc_t2, cc_t1, cc_term}, 8'hFC);
    wr(usbepd_pkg::ADDR_PD_CONTROL, 8'hA9);
    chk({pd_mode, pd_send, pd_recv, cc_sel, cc_t2, cc_t1, cc_term}, 8'hA9);
    wr(usbepd_pkg::ADDR_PD_CONTROL, 8'h62);
    chk({pd_mode, pd_send, pd_recv, cc_sel, cc_t2, cc_t1, cc_term}, 8'h02);
    rdchk(usbepd_pkg::ADDR_PD_CONTROL, 8'h62);
    host.set_lines(1'b1, 1'b0);
    rdchk(usbepd_pkg::ADDR_AUX_STATUS, 8'h80);
    host.set_lines(1'b0, 1'b0);
    rdchk(usbepd_pkg::ADDR_AUX_STATUS, 8'h40);
    wr(usbepd_pkg::ADDR_AUX_STATUS, 8'h00);
    rdchk(usbepd_pkg::ADDR_AUX_STATUS, 8'h00);
    wr(usbepd_pkg::ADDR_ENDPOINT_IRQ_EN, 8'h01);
    host.pulse_events(8'h80, 6'h00);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(irq, 1'b0);
    host.pulse_events(8'h01, 6'h00);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(irq, 1'b1);
    rdchk(usbepd_pkg::ADDR_ENDPOINT_FLAGS, 8'h81);
    wr(usbepd_pkg::ADDR_ENDPOINT_FLAGS, 8'h00);
    chk(irq, 1'b0);
    wr(usbepd_pkg::ADDR_BUS_EVENT_IRQ_EN, 8'h04);
    host.pulse_events(8'h00, 6'h21);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(irq, 1'b1);
    rdchk(usbepd_pkg::ADDR_BUS_EVENT_FLAGS, 8'h84);
    wr(usbepd_pkg::ADDR_BUS_EVENT_FLAGS, 8'h00);
    chk(irq, 1'b0);
    for (int s = 0; s < 4; s++) tmo_run(8'h04 | s[7:0], (2 + s) * CYC);
    tmo_run(8'h03, 0);
    results();
  end
endmodule : testbench
